// ---- hdl/pcs_pkg.sv ----
// Operation
// - role setting 1 makes a coordinator, 0 (default) an end device.
// - coordinator hold period 0 forwards data at once, else hold then discard; end devices always forward at once.
// - coordinator checks join flag bit 0 at power-up; set means scan.
// - each beacon request goes to address 0xFFFF on PAN 0xFFFF.
// - listen one dwell time per channel, then move on.
// - scan ends after all channels or 5 networks; record PAN and channel.
// - keep configured PAN unless found; otherwise choose an unused one.
// - join flag bit 0 clear skips the scan, PAN stays unchanged.
// - end device join flags decide which values a join may adopt.
// - join flag bit 1 energy-scans, picks quietest channel not in use.
// - start on chosen channel and PAN; joins only with allow flag set.
// - end device join flag bit 2 set means attempt to join.
`default_nettype none

package pcs_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCAN_UNIT_NS  = 1000000;   // one dwell unit, 1 ms
    localparam int HOLD_UNIT_NS  = 10000000;  // one hold unit, 10 ms
    localparam int PRE_W         = 24;

    // widths
    localparam int FLAG_W = 8;
    localparam int CHAN_W = 5;
    localparam int PAN_W  = 16;
    localparam int CNT_W  = 3;
    localparam int TIME_W = 16;
    localparam int NRG_W  = 8;

    // values
    localparam logic              ROLE_COORD    = 1'b1;
    localparam logic [PAN_W-1:0]  BCAST_ADDR    = 16'hffff;
    localparam logic [PAN_W-1:0]  PAN_LAST_FREE = 16'hfffd;
    localparam logic [CHAN_W-1:0] CHAN_FIRST    = 5'h0b;
    localparam logic [CHAN_W-1:0] CHAN_LAST     = 5'h1a;
    localparam logic [CNT_W-1:0]  MAX_NETS      = 3'h5;
    localparam logic [NRG_W-1:0]  ENERGY_MAX    = 8'hff;
    localparam logic [TIME_W-1:0] HOLD_NONE     = 16'h0000;

    // flag bit positions
    localparam int CJF_PAN_BIT   = 0;
    localparam int CJF_CHAN_BIT  = 1;
    localparam int CJF_ALLOW_BIT = 2;
    localparam int EJF_PAN_BIT   = 0;
    localparam int EJF_CHAN_BIT  = 1;
    localparam int EJF_AUTO_BIT  = 2;
    localparam int EJF_DEST_BIT  = 3;

    typedef struct packed {
        logic [PAN_W-1:0]  pan;
        logic [CHAN_W-1:0] chan;
    } pcs_net_type;

    typedef struct packed {
        logic [PAN_W-1:0]  dst;
        logic [PAN_W-1:0]  pan;
        logic [CHAN_W-1:0] chan;
    } pcs_frame_type;

    typedef pcs_net_type pcs_table_type [5];

    typedef enum logic [9:0] {
        ST_CHECK  = 10'h001,
        ST_AREQ   = 10'h002,
        ST_AWAIT  = 10'h004,
        ST_PICK   = 10'h008,
        ST_EREQ   = 10'h010,
        ST_EWAIT  = 10'h020,
        ST_START  = 10'h040,
        ST_RUN    = 10'h080,
        ST_JOIN   = 10'h100,
        ST_ED_RUN = 10'h200
    } pcs_state_type;
endpackage : pcs_pkg

`default_nettype wire

// ---- hdl/pcs_unit_timer.sv ----
`default_nettype none

module pcs_unit_timer #(
    parameter int UNIT_CYC = 1
) (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    // control
    input  wire logic                      start,
    input  wire logic                      abort,
    input  wire logic [pcs_pkg::TIME_W-1:0] units,
    // result
    output var  logic                      expired
);
    import pcs_pkg::*;

    localparam logic [PRE_W-1:0] UNIT_M1 = PRE_W'(UNIT_CYC - 1);

    logic              active;
    logic              next_active;
    logic [PRE_W-1:0]  pre;
    logic [PRE_W-1:0]  next_pre;
    logic [TIME_W-1:0] left;
    logic [TIME_W-1:0] next_left;
    logic              next_expired;

    // a zero count still waits one unit so a dwell never collapses
    always_comb begin
        next_active  = active;
        next_pre     = pre;
        next_left    = left;
        next_expired = 1'b0;
        if (start) begin
            next_active = 1'b1;
            next_pre    = '0;
            next_left   = (units == '0) ? TIME_W'(1) : units;
        end else if (abort) begin
            next_active = 1'b0;
        end else if (active) begin
            if (pre == UNIT_M1) begin
                next_pre = '0;
                if (left == TIME_W'(1)) begin
                    next_active  = 1'b0;
                    next_expired = 1'b1;
                end else begin
                    next_left = left - TIME_W'(1);
                end
            end else begin
                next_pre = pre + PRE_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            active  <= 1'b0;
            pre     <= '0;
            left    <= '0;
            expired <= 1'b0;
        end else begin
            active  <= next_active;
            pre     <= next_pre;
            left    <= next_left;
            expired <= next_expired;
        end
    end
endmodule : pcs_unit_timer

`default_nettype wire

// ---- hdl/pcs_top.sv ----
`default_nettype none

module pcs_top #(
    parameter int DWELL_UNIT_CYC = pcs_pkg::SCAN_UNIT_NS / pcs_pkg::CLK_PERIOD_NS,
    parameter int HOLD_UNIT_CYC  = pcs_pkg::HOLD_UNIT_NS / pcs_pkg::CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rstn,
    // configuration settings
    input  wire logic                        coordinator_enable,
    input  wire logic [pcs_pkg::FLAG_W-1:0]  coordinator_join_flags,
    input  wire logic [pcs_pkg::FLAG_W-1:0]  end_device_join_flags,
    input  wire logic [pcs_pkg::TIME_W-1:0]  hold_period,
    input  wire logic [pcs_pkg::TIME_W-1:0]  scan_dwell_time,
    input  wire logic [pcs_pkg::PAN_W-1:0]   pan_number,
    input  wire logic [pcs_pkg::CHAN_W-1:0]  radio_frequency_slot,
    // radio events
    input  wire logic                        beacon_valid,
    input  wire pcs_pkg::pcs_net_type        beacon_net,
    input  wire logic                        energy_valid,
    input  wire logic [pcs_pkg::NRG_W-1:0]   energy_level,
    input  wire logic                        join_grant,
    input  wire pcs_pkg::pcs_net_type        grant_net,
    input  wire logic [pcs_pkg::PAN_W-1:0]   grant_dest,
    // outgoing data queue
    input  wire logic                        data_queued,
    input  wire logic                        data_collected,
    output var  logic                        data_forward,
    output var  logic                        data_discard,
    // radio requests
    output var  logic                        beacon_req,
    output var  logic                        energy_req,
    output var  pcs_pkg::pcs_frame_type      tx_frame,
    // status and resulting settings
    output var  logic                        scan_done,
    output var  logic                        network_up,
    output var  logic                        accept_joins,
    output var  logic                        join_attempt,
    output var  logic [pcs_pkg::PAN_W-1:0]   pan_out,
    output var  logic [pcs_pkg::CHAN_W-1:0]  chan_out,
    output var  logic [pcs_pkg::PAN_W-1:0]   dest_out
);
    import pcs_pkg::*;

    pcs_state_type state, next_state;
    pcs_table_type nets, next_nets;
    logic [CNT_W-1:0]  net_count, next_net_count;
    logic [CHAN_W-1:0] scan_chan, next_scan_chan;
    logic [CHAN_W-1:0] best_chan, next_best_chan;
    logic [NRG_W-1:0]  best_energy, next_best_energy;
    logic [NRG_W-1:0]  cur_energy, next_cur_energy;
    logic              next_beacon_req, next_energy_req, next_scan_done;
    logic              next_network_up, next_accept_joins, next_join_attempt;
    logic [PAN_W-1:0]  next_pan_out, next_dest_out;
    logic [CHAN_W-1:0] next_chan_out;
    pcs_frame_type     next_tx_frame;
    logic              dwell_expired, hold_expired, hold_start;
    logic              hold_busy, next_hold_busy;
    logic              next_data_forward, next_data_discard;

    // lookups over the found-network table; entries past count are ignored
    function automatic logic pan_in_use(pcs_table_type t,
                                        logic [CNT_W-1:0] n,
                                        logic [PAN_W-1:0] p);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 5; i++)
            if (CNT_W'(i) < n && t[i].pan == p) hit = 1'b1;
        return hit;
    endfunction : pan_in_use

    function automatic logic chan_in_use(pcs_table_type t,
                                         logic [CNT_W-1:0] n,
                                         logic [CHAN_W-1:0] c);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 5; i++)
            if (CNT_W'(i) < n && t[i].chan == c) hit = 1'b1;
        return hit;
    endfunction : chan_in_use

    function automatic logic net_seen(pcs_table_type t,
                                      logic [CNT_W-1:0] n,
                                      pcs_net_type b);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 5; i++)
            if (CNT_W'(i) < n && t[i] == b) hit = 1'b1;
        return hit;
    endfunction : net_seen

    // one timer serves both scans since they never overlap
    pcs_unit_timer #(.UNIT_CYC(DWELL_UNIT_CYC)) u_dwell (
        .core_clk (core_clk),
        .rstn     (rstn),
        .start    (beacon_req | energy_req),
        .abort    (1'b0),
        .units    (scan_dwell_time),
        .expired  (dwell_expired)
    );

    pcs_unit_timer #(.UNIT_CYC(HOLD_UNIT_CYC)) u_hold (
        .core_clk (core_clk),
        .rstn     (rstn),
        .start    (hold_start),
        .abort    (data_collected),
        .units    (hold_period),
        .expired  (hold_expired)
    );

    // power-up sequencer: scans, identifier and channel choice, start
    always_comb begin
        logic take;
        take              = 1'b0;
        next_state        = state;
        next_nets         = nets;
        next_net_count    = net_count;
        next_scan_chan    = scan_chan;
        next_best_chan    = best_chan;
        next_best_energy  = best_energy;
        next_cur_energy   = cur_energy;
        next_pan_out      = pan_out;
        next_chan_out     = chan_out;
        next_dest_out     = dest_out;
        next_network_up   = network_up;
        next_join_attempt = join_attempt;
        next_scan_done    = 1'b0;
        next_accept_joins = 1'b0;
        unique case (state)
            ST_CHECK: begin
                next_pan_out   = pan_number;
                next_chan_out  = radio_frequency_slot;
                next_dest_out  = '0;
                next_net_count = '0;
                next_scan_chan = CHAN_FIRST;
                next_best_chan = radio_frequency_slot;
                next_best_energy = ENERGY_MAX;
                if (coordinator_enable == ROLE_COORD) begin
                    if (coordinator_join_flags[CJF_PAN_BIT])
                        next_state = ST_AREQ;
                    else if (coordinator_join_flags[CJF_CHAN_BIT])
                        next_state = ST_EREQ;
                    else
                        next_state = ST_START;
                end else if (end_device_join_flags[EJF_AUTO_BIT]) begin
                    next_state        = ST_JOIN;
                    next_join_attempt = 1'b1;
                end else begin
                    next_state      = ST_ED_RUN;
                    next_network_up = 1'b1;
                end
            end
            ST_AREQ: next_state = ST_AWAIT;
            ST_AWAIT: begin
                // record each distinct network once
                if (beacon_valid && net_count < MAX_NETS
                    && !net_seen(nets, net_count, beacon_net)) begin
                    next_nets[net_count] = beacon_net;
                    next_net_count = net_count + CNT_W'(1);
                end
                if (next_net_count == MAX_NETS
                    || (dwell_expired && scan_chan == CHAN_LAST))
                    next_state = ST_PICK;
                else if (dwell_expired) begin
                    next_scan_chan = scan_chan + CHAN_W'(1);
                    next_state     = ST_AREQ;
                end
            end
            ST_PICK: begin
                // step past clashes, never onto the broadcast values
                if (pan_in_use(nets, net_count, pan_out))
                    next_pan_out = (pan_out >= PAN_LAST_FREE) ?
                                   '0 : pan_out + PAN_W'(1);
                else if (coordinator_join_flags[CJF_CHAN_BIT]) begin
                    next_scan_chan = CHAN_FIRST;
                    next_state     = ST_EREQ;
                end else
                    next_state = ST_START;
            end
            ST_EREQ: begin
                next_cur_energy = '0;
                next_state      = ST_EWAIT;
            end
            ST_EWAIT: begin
                if (energy_valid && energy_level > cur_energy)
                    next_cur_energy = energy_level;
                // quietest free channel wins; ties keep the earlier one
                take = !chan_in_use(nets, net_count, scan_chan)
                       && cur_energy < best_energy;
                if (dwell_expired) begin
                    if (take) begin
                        next_best_chan   = scan_chan;
                        next_best_energy = cur_energy;
                    end
                    if (scan_chan == CHAN_LAST) begin
                        next_chan_out = take ? scan_chan : best_chan;
                        next_state    = ST_START;
                    end else begin
                        next_scan_chan = scan_chan + CHAN_W'(1);
                        next_state     = ST_EREQ;
                    end
                end
            end
            ST_START: begin
                next_network_up = 1'b1;
                next_state      = ST_RUN;
            end
            ST_RUN: next_accept_joins =
                        coordinator_join_flags[CJF_ALLOW_BIT];
            ST_JOIN: begin
                // adopt only what the join flags release
                if (join_grant) begin
                    if (end_device_join_flags[EJF_PAN_BIT])
                        next_pan_out = grant_net.pan;
                    if (end_device_join_flags[EJF_CHAN_BIT])
                        next_chan_out = grant_net.chan;
                    if (end_device_join_flags[EJF_DEST_BIT])
                        next_dest_out = grant_dest;
                    next_join_attempt = 1'b0;
                    next_network_up   = 1'b1;
                    next_state        = ST_ED_RUN;
                end
            end
            ST_ED_RUN: next_state = ST_ED_RUN;
            default:   next_state = ST_CHECK;
        endcase
        next_beacon_req = (next_state == ST_AREQ);
        next_energy_req = (next_state == ST_EREQ);
        // completion stands in the start cycle, a cycle ahead of network_up
        next_scan_done  = (next_state == ST_START);
        next_tx_frame   = '{dst: BCAST_ADDR, pan: BCAST_ADDR,
                            chan: next_scan_chan};
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state        <= ST_CHECK;
            nets         <= '{default: '0};
            net_count    <= '0;
            scan_chan    <= '0;
            best_chan    <= '0;
            best_energy  <= '0;
            cur_energy   <= '0;
            pan_out      <= '0;
            chan_out     <= '0;
            dest_out     <= '0;
            network_up   <= 1'b0;
            join_attempt <= 1'b0;
            scan_done    <= 1'b0;
            accept_joins <= 1'b0;
            beacon_req   <= 1'b0;
            energy_req   <= 1'b0;
            tx_frame     <= '0;
        end else begin
            state        <= next_state;
            nets         <= next_nets;
            net_count    <= next_net_count;
            scan_chan    <= next_scan_chan;
            best_chan    <= next_best_chan;
            best_energy  <= next_best_energy;
            cur_energy   <= next_cur_energy;
            pan_out      <= next_pan_out;
            chan_out     <= next_chan_out;
            dest_out     <= next_dest_out;
            network_up   <= next_network_up;
            join_attempt <= next_join_attempt;
            scan_done    <= next_scan_done;
            accept_joins <= next_accept_joins;
            beacon_req   <= next_beacon_req;
            energy_req   <= next_energy_req;
            tx_frame     <= next_tx_frame;
        end
    end

    // outgoing data hold; a new item restarts the hold of the old one
    assign hold_start = data_queued && coordinator_enable == ROLE_COORD
                        && hold_period != HOLD_NONE;
    always_comb begin
        next_hold_busy    = hold_busy;
        next_data_forward = 1'b0;
        next_data_discard = 1'b0;
        if (data_queued) begin
            if (hold_start)
                next_hold_busy = 1'b1;
            else
                next_data_forward = 1'b1;
        end else if (hold_busy && data_collected) begin
            next_hold_busy    = 1'b0;
            next_data_forward = 1'b1;
        end else if (hold_busy && hold_expired) begin
            next_hold_busy    = 1'b0;
            next_data_discard = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            hold_busy    <= 1'b0;
            data_forward <= 1'b0;
            data_discard <= 1'b0;
        end else begin
            hold_busy    <= next_hold_busy;
            data_forward <= next_data_forward;
            data_discard <= next_data_discard;
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_role_select: assert property (state == ST_CHECK && !coordinator_enable
        |=> !beacon_req && !energy_req)
        else $error("end device started a scan");
    a_hold_direct: assert property (data_queued && hold_period == HOLD_NONE
        |=> data_forward && !data_discard)
        else $error("zero hold did not forward at once");
    a_scan_first: assert property (state == ST_CHECK && coordinator_enable
        && coordinator_join_flags[CJF_PAN_BIT]
        |=> beacon_req && tx_frame.chan == CHAN_FIRST)
        else $error("active scan did not start on first channel");
    a_beacon_bcast: assert property (beacon_req |-> tx_frame.dst == BCAST_ADDR
        && tx_frame.pan == BCAST_ADDR)
        else $error("beacon request not broadcast");
    a_dwell_next: assert property (state == ST_AWAIT && dwell_expired
        && scan_chan != CHAN_LAST && net_count < MAX_NETS - CNT_W'(1)
        |=> beacon_req && tx_frame.chan == $past(scan_chan) + CHAN_W'(1))
        else $error("scan did not move to next channel");
    a_net_limit: assert property (beacon_req |-> net_count < MAX_NETS)
        else $error("scan went on after five networks");
    a_pan_free: assert property ($rose(network_up) && coordinator_enable
        && coordinator_join_flags[CJF_PAN_BIT]
        |-> !pan_in_use(nets, net_count, pan_out))
        else $error("started on a clashing identifier");
    a_pan_kept: assert property ($rose(network_up) && coordinator_enable
        && !coordinator_join_flags[CJF_PAN_BIT]
        |-> pan_out == $past(pan_number, 2))
        else $error("identifier changed without a scan");
    a_chan_kept: assert property ($rose(network_up) && coordinator_enable
        && !coordinator_join_flags[CJF_CHAN_BIT] |-> chan_out ==
        $past(radio_frequency_slot, 2) || coordinator_join_flags[CJF_PAN_BIT])
        else $error("channel changed without energy scan");
    a_join_gate: assert property (accept_joins |-> network_up
        && $past(coordinator_join_flags[CJF_ALLOW_BIT]))
        else $error("joins accepted without allow flag");
    a_ed_nojoin: assert property (state == ST_CHECK && !coordinator_enable
        && !end_device_join_flags[EJF_AUTO_BIT]
        |=> !join_attempt && network_up)
        else $error("end device tried to join");
    a_done_first: assert property ($rose(network_up) && state == ST_RUN
        |-> $past(scan_done) && !scan_done)
        else $error("start without completion flag");

    c_coord_up: cover property ($rose(network_up) && coordinator_enable);
    c_five_nets: cover property (net_count == MAX_NETS);
    c_discard: cover property (data_discard);
    c_pan_moved: cover property (state == ST_PICK && next_pan_out != pan_out);
endmodule : pcs_top

`default_nettype wire

// ---- tb/pcs_peer_model.sv ----
`default_nettype none
// far-side radio: one peer network answers beacon requests on its channel
module pcs_peer_model (
    // requests from the block
    input  wire logic                   core_clk,
    input  wire logic                   beacon_req,
    input  wire logic                   energy_req,
    input  wire pcs_pkg::pcs_frame_type tx_frame,
    input  wire pcs_pkg::pcs_net_type   peer_net,
    // radio events back
    output var  logic                   beacon_valid = 1'b0,
    output var  pcs_pkg::pcs_net_type   beacon_net = '0,
    output var  logic                   energy_valid = 1'b0,
    output var  logic [7:0]             energy_level = 8'h00
);
    import pcs_pkg::*;
    logic hit = 1'b0;
    // beacons answer two cycles on, energy one cycle on; idle lines toggle so stale data never looks valid
    always @(posedge core_clk) begin
        hit <= beacon_req && tx_frame.chan == peer_net.chan;
        beacon_valid <= hit;
        beacon_net <= hit ? peer_net : ~beacon_net;
        energy_valid <= energy_req;
        energy_level <= energy_req ? {3'h0, tx_frame.chan} : ~energy_level;
    end
endmodule : pcs_peer_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pcs_pkg::*;
    logic core_clk = 0, rstn = 0, ce = 0, dq = 0, dc = 0;
    logic [7:0] cjf = 0, ejf = 0, el;
    logic [15:0] hold = 0, po, dso;
    logic [15:0] pn = 16'h1234, sdt = 16'h0001;
    logic [4:0] rfs = 5'h0f;
    logic jg = 0;
    logic [4:0] co, lastc;
    logic bv, ev, bq, eq, sd, up, aj, ja, df, dd;
    pcs_net_type bn, peer = '{16'h1234, 5'h0b}, gn = '{16'h4321, 5'h14};
    pcs_frame_type tf;
    int bad_count = 0, total_checks = 0, nreq, nsd, oerr, n;
    pcs_top #(.DWELL_UNIT_CYC(4), .HOLD_UNIT_CYC(8)) DUT (.core_clk,
        .rstn, .coordinator_enable(ce), .coordinator_join_flags(cjf),
        .end_device_join_flags(ejf), .hold_period(hold),
        .scan_dwell_time(sdt), .pan_number(pn),
        .radio_frequency_slot(rfs), .beacon_valid(bv), .beacon_net(bn),
        .energy_valid(ev), .energy_level(el), .join_grant(jg),
        .grant_net(gn), .grant_dest(16'h0000), .data_queued(dq),
        .data_collected(dc), .data_forward(df), .data_discard(dd),
        .beacon_req(bq), .energy_req(eq), .tx_frame(tf), .scan_done(sd),
        .network_up(up), .accept_joins(aj), .join_attempt(ja),
        .pan_out(po), .chan_out(co), .dest_out(dso));
    pcs_peer_model peer_i (.core_clk, .beacon_req(bq), .energy_req(eq),
        .tx_frame(tf), .peer_net(peer), .beacon_valid(bv),
        .beacon_net(bn), .energy_valid(ev), .energy_level(el));
    always #12.5 core_clk = ~core_clk;
    // watch every beacon request: broadcast target, one channel up each time
    always @(posedge core_clk) begin
        if (bq === 1'b1) begin
            nreq++;
            if (tf.dst !== BCAST_ADDR || tf.pan !== BCAST_ADDR)
                oerr++;
            if (tf.chan !== lastc + 5'h01) oerr++;
            lastc = tf.chan;
        end
        if (sd === 1'b1) nsd++;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // the power-up sequence only runs once after reset, so each test reboots
    task automatic boot(input logic c, input logic [7:0] f, input int h);
        @(posedge core_clk);
        #1 rstn = 0;
        {ce, cjf, hold} = {c, f, h[15:0]};
        {nreq, nsd, oerr, lastc} = {32'd0, 32'd0, 32'd0, 5'h0a};
        repeat (16) @(posedge core_clk);
        #1 rstn = 1;
    endtask : boot
    task automatic wait_up(input int lim);
        for (int i = 0; i < lim && up !== 1'b1; i++) @(posedge core_clk) #1;
        if (up !== 1'b1) begin
            bad_count++;
            end_sim();
        end
    endtask : wait_up
    // queue one item, count cycles until it is forwarded or dropped
    task automatic queue(input int lim);
        dq = 1;
        @(posedge core_clk) #1 dq = 0;
        // look before waiting: a direct forward stands in the first cycle
        for (n = 1; n <= lim; n++) begin
            if (df === 1'b1 || dd === 1'b1) break;
            @(posedge core_clk) #1;
        end
        if (n > lim) begin
            bad_count++;
            end_sim();
        end
    endtask : queue
    task automatic t_end_device;
        boot(0, 8'h00, 0);
        wait_up(20);
        chk(po, 16'h1234);
        chk(ja, 0);
        chk(nsd + nreq, 0);
        $display("end device test done");
    endtask : t_end_device
    task automatic t_no_scan;
        boot(1, 8'h04, 0);
        wait_up(20);
        chk(nsd, 1);
        chk(nreq, 0);
        chk(po, 16'h1234);
        @(posedge core_clk) #1;
        chk(aj, 1);
        queue(20);
        chk({n[14:0], df}, 16'h0003);
        $display("coordinator no scan test done");
    endtask : t_no_scan
    task automatic t_scan;
        boot(1, 8'h01, 1);
        wait_up(400);
        chk(nreq, 16);
        chk(oerr, 0);
        chk(po, 16'h1235);
        chk(co, 16'h000f);
        @(posedge core_clk) #1;
        chk(aj, 0);
        queue(30);
        chk({n[14:0], dd}, 16'h0015);
        $display("coordinator scan test done");
    endtask : t_scan
    // model energy equals channel number, so the first channel is quietest
    task automatic t_energy;
        sdt = 16'h0002;
        boot(1, 8'h02, 0);
        wait_up(400);
        chk(co, CHAN_FIRST);
        chk(nreq, 0);
        chk(po, pn);
        $display("coordinator energy scan test done");
    endtask : t_energy
    task automatic t_join;
        ejf = 8'h05;
        boot(0, 8'h00, 0);
        @(posedge core_clk) #1;
        chk(ja, 1);
        chk(up, 0);
        jg = 1;
        @(posedge core_clk) #1 jg = 0;
        chk(po, 16'h4321);
        chk(co, rfs);
        chk({ja, up}, 2'b01);
        $display("end device join test done");
    endtask : t_join
    initial begin
        t_end_device();
        t_no_scan();
        t_scan();
        t_energy();
        t_join();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
